// *** pkg/vsg_consts.svh ***
// constants for the vacant space and write guard
`ifndef VSG_CONSTS_SVH
`define VSG_CONSTS_SVH
// ****************************************
// bus values and password
// ****************************************
`define VSG_PAD_WORD 16'h3FFF
`define VSG_PWD_KEY 8'hA5
`define VSG_PWD_LSB 8
`define VSG_PWD_MSB 15
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define VSG_CFG_OFS 12'h000
`define VSG_CTRL_OFS 12'h004
`define VSG_STAT_OFS 12'h008
// ****************************************
// field positions and reset values
// ****************************************
`define VSG_PROG_LOCK_BIT 0
`define VSG_DATA_LOCK_BIT 1
`define VSG_IRQ_EN_BIT 0
`define VSG_STAT_BOOT_BIT 16
`define VSG_LOCK_RST 2'b11
`define VSG_IRQ_EN_RST 1'b0
// ****************************************
// memory map
// ****************************************
`define VSG_PERIPH_HI 16'h0FFF
`define VSG_PERIPH_USED_HI 16'h07FF
`define VSG_BOOT_LO 16'h1000
`define VSG_BOOT_HI 16'h17FF
`define VSG_DATA_LO 16'h1800
`define VSG_DATA_HI_SMALL 16'h18FF
`define VSG_DATA_HI_LARGE 16'h19FF
`define VSG_RAM_LO 16'h2000
`define VSG_RAM_HI 16'h27FF
`define VSG_PROG_LO 16'hC000
`endif

// *** pkg/vsg_pkg.sv ***
// types shared by the guard and its decoder
package vsg_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic [15:0] addr;
  } vsg_bus_req_type;
  typedef struct packed {
    logic rdata_override;
    logic [15:0] rdata;
    logic write_block;
    logic nmi;
    logic power_up_clear_reset;
  } vsg_bus_rsp_type;
  typedef struct packed {
    logic vacant;
    logic periph;
    logic in_boot;
    logic in_prog;
    logic in_data;
  } vsg_class_type;
  typedef enum logic [0:0] {
    VSG_ST_IDLE = 1'b0,
    VSG_ST_ACK = 1'b1
  } vsg_apb_state_type;
endpackage

// *** rtl/vsg_decode.sv ***
// address classifier for the guard
`timescale 1ns/1ps
`include "vsg_consts.svh"
module vsg_decode #(
  parameter logic [15:0] DATA_HI = `VSG_DATA_HI_SMALL,
  parameter logic [15:0] PERIPH_USED_HI = `VSG_PERIPH_USED_HI,
  parameter logic [15:0] RAM_HI = `VSG_RAM_HI,
  parameter logic [15:0] PROG_LO = `VSG_PROG_LO
) (
  input wire logic [15:0] i_addr,
  input wire logic i_boot_retired,
  output vsg_pkg::vsg_class_type o_class
);
  import vsg_pkg::*;
  logic live_periph;
  logic live_boot;
  logic in_ram;
  always_comb begin
    o_class.periph = (i_addr <= `VSG_PERIPH_HI);
    o_class.in_boot = (i_addr >= `VSG_BOOT_LO) && (i_addr <= `VSG_BOOT_HI);
    o_class.in_data = (i_addr >= `VSG_DATA_LO) && (i_addr <= DATA_HI);
    o_class.in_prog = (i_addr >= PROG_LO);
    in_ram = (i_addr >= `VSG_RAM_LO) && (i_addr <= RAM_HI);
    live_periph = (i_addr <= PERIPH_USED_HI);
    // retired boot code reads as nonexistent
    live_boot = o_class.in_boot && !i_boot_retired;
    o_class.vacant = !(live_periph || live_boot || o_class.in_data || in_ram
                       || o_class.in_prog);
  end
endmodule // vsg_decode

// *** rtl/vsg_guard.sv ***
// vacant space and write guard with apb configuration
// Operation
// - vacant access other than a peripheral fetch raises the system nonmaskable request when its enable is set
// - reads from vacant space return 3FFFh instead of memory data
// - vacant fetch returns 3FFFh, a jump to itself, so cpu loops
// - fetch from vacant peripheral space raises power-up-clear reset
// - after boot code finishes its range behaves as vacant space
// - program region has its own write lock bit in config word
// - data region 1800h to 18FFh or 19FFh has separate lock bit
// - lock bits change only when the same write carries the password
// - writes to a locked region are dropped without irq or reset
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "vsg_consts.svh"
module vsg_guard #(
  parameter bit LARGE_DATA = 1'b0,
  parameter logic [15:0] PERIPH_USED_HI = `VSG_PERIPH_USED_HI,
  parameter logic [15:0] RAM_HI = `VSG_RAM_HI,
  parameter logic [15:0] PROG_LO = `VSG_PROG_LO
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input vsg_pkg::vsg_bus_req_type i_req,
  input wire logic i_boot_done,
  output vsg_pkg::vsg_bus_rsp_type o_rsp,
  output logic o_program_region_write_lock,
  output logic o_data_region_write_lock
);
  import vsg_pkg::*;
  localparam logic [15:0] DATA_HI = LARGE_DATA ? `VSG_DATA_HI_LARGE : `VSG_DATA_HI_SMALL;
  // lock outputs must come out of reset with the same value as the lock bits
  localparam logic [1:0] LOCK_RST = `VSG_LOCK_RST;

  // ****************************************
  // address classification
  // ****************************************
  vsg_class_type cls;
  logic boot_retired_reg;
  logic boot_retired_next;
  vsg_decode #(
    .DATA_HI(DATA_HI),
    .PERIPH_USED_HI(PERIPH_USED_HI),
    .RAM_HI(RAM_HI),
    .PROG_LO(PROG_LO)
  ) u_decode (
    .i_addr(i_req.addr),
    .i_boot_retired(boot_retired_reg),
    .o_class(cls)
  );

  // ****************************************
  // apb slave
  // ****************************************
  vsg_apb_state_type state_reg;
  vsg_apb_state_type state_next;
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic [1:0] lock_reg;
  logic [1:0] lock_next;
  logic irq_en_reg;
  logic irq_en_next;
  logic [15:0] last_vac_reg;
  logic [15:0] last_vac_next;
  logic commit;
  logic key_ok;
  logic mapped;

  always_comb begin
    state_next = state_reg;
    prdata_next = o_prdata;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    mapped = (i_paddr == `VSG_CFG_OFS) || (i_paddr == `VSG_CTRL_OFS)
             || (i_paddr == `VSG_STAT_OFS);
    case (state_reg)
      VSG_ST_IDLE: begin
        if (i_psel && !i_penable) begin
          // answer is prepared in setup so the access phase lasts one cycle
          state_next = VSG_ST_ACK;
          pready_next = 1'b1;
          pslverr_next = !mapped;
          prdata_next = 32'h0000_0000;
          if (!i_pwrite) begin
            case (i_paddr)
              `VSG_CFG_OFS: prdata_next = {30'h0000_0000, lock_reg};
              `VSG_CTRL_OFS: prdata_next = {31'h0000_0000, irq_en_reg};
              `VSG_STAT_OFS: prdata_next = {15'h0000, boot_retired_reg, last_vac_reg};
              default: prdata_next = 32'h0000_0000;
            endcase
          end
        end
      end
      VSG_ST_ACK: begin
        state_next = VSG_ST_IDLE;
      end
      default: begin
        state_next = VSG_ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_comb begin
    commit = (state_reg == VSG_ST_ACK) && i_psel && i_penable && i_pwrite && o_pready;
    key_ok = (i_pwdata[`VSG_PWD_MSB:`VSG_PWD_LSB] == `VSG_PWD_KEY);
    lock_next = lock_reg;
    irq_en_next = irq_en_reg;
    // a write without the key keeps both locks as they were
    if (commit && (i_paddr == `VSG_CFG_OFS) && key_ok) begin
      lock_next[`VSG_PROG_LOCK_BIT] = i_pwdata[`VSG_PROG_LOCK_BIT];
      lock_next[`VSG_DATA_LOCK_BIT] = i_pwdata[`VSG_DATA_LOCK_BIT];
    end
    if (commit && (i_paddr == `VSG_CTRL_OFS)) begin
      irq_en_next = i_pwdata[`VSG_IRQ_EN_BIT];
    end
  end

  // ****************************************
  // bus guard
  // ****************************************
  vsg_bus_rsp_type rsp_next;
  logic vac_hit;
  logic periph_fetch;
  always_comb begin
    vac_hit = i_req.valid && cls.vacant;
    periph_fetch = vac_hit && i_req.fetch && cls.periph;
    boot_retired_next = boot_retired_reg || i_boot_done;
    last_vac_next = vac_hit ? i_req.addr : last_vac_reg;
    rsp_next = '0;
    // vacant reads and fetches see the pad word, which decodes as a self jump
    rsp_next.rdata_override = vac_hit && !i_req.write;
    rsp_next.rdata = vac_hit ? `VSG_PAD_WORD : 16'h0000;
    rsp_next.power_up_clear_reset = periph_fetch;
    // the reset supersedes the interrupt on a peripheral fetch
    rsp_next.nmi = vac_hit && irq_en_reg && !periph_fetch;
    rsp_next.write_block = i_req.valid && i_req.write && (cls.vacant
      || (cls.in_prog && lock_reg[`VSG_PROG_LOCK_BIT])
      || (cls.in_data && lock_reg[`VSG_DATA_LOCK_BIT]));
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= VSG_ST_IDLE;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      lock_reg <= `VSG_LOCK_RST;
      irq_en_reg <= `VSG_IRQ_EN_RST;
      boot_retired_reg <= 1'b0;
      last_vac_reg <= 16'h0000;
      o_rsp <= '0;
      o_program_region_write_lock <= LOCK_RST[`VSG_PROG_LOCK_BIT];
      o_data_region_write_lock <= LOCK_RST[`VSG_DATA_LOCK_BIT];
    end else begin
      state_reg <= state_next;
      o_prdata <= prdata_next;
      o_pready <= pready_next;
      o_pslverr <= pslverr_next;
      lock_reg <= lock_next;
      irq_en_reg <= irq_en_next;
      boot_retired_reg <= boot_retired_next;
      last_vac_reg <= last_vac_next;
      o_rsp <= rsp_next;
      o_program_region_write_lock <= lock_next[`VSG_PROG_LOCK_BIT];
      o_data_region_write_lock <= lock_next[`VSG_DATA_LOCK_BIT];
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_cfg_setup;
    i_psel && !i_penable && i_pwrite && (i_paddr == `VSG_CFG_OFS);
  endsequence
  sequence s_cfg_access;
    i_psel && i_penable && o_pready;
  endsequence

  chk_nmi_vacant: assert property (
    (vac_hit && irq_en_reg && !(i_req.fetch && cls.periph)) |=> o_rsp.nmi)
    else $error("vacant access gave no nmi");
  chk_nmi_gated: assert property (
    o_rsp.nmi |-> $past(irq_en_reg) && $past(vac_hit))
    else $error("nmi without enable or vacant hit");
  chk_pad_word: assert property (
    o_rsp.rdata_override |-> (o_rsp.rdata == `VSG_PAD_WORD))
    else $error("vacant read data wrong");
  chk_fetch_loop: assert property (
    (vac_hit && i_req.fetch && !i_req.write && !cls.periph)
      |=> o_rsp.rdata_override && !o_rsp.power_up_clear_reset)
    else $error("vacant fetch not padded");
  chk_reset_fetch: assert property (
    (vac_hit && i_req.fetch && cls.periph) |=> o_rsp.power_up_clear_reset && !o_rsp.nmi)
    else $error("peripheral vacant fetch missed reset");
  chk_boot_vacant: assert property (
    (boot_retired_reg && i_req.valid && !i_req.write && cls.in_boot)
      |=> o_rsp.rdata_override)
    else $error("retired boot range not vacant");
  chk_prog_block: assert property (
    (i_req.valid && i_req.write && cls.in_prog && lock_reg[`VSG_PROG_LOCK_BIT])
      |=> o_rsp.write_block && !o_rsp.nmi && !o_rsp.power_up_clear_reset)
    else $error("locked program write not dropped");
  chk_data_block: assert property (
    (i_req.valid && i_req.write && cls.in_data && lock_reg[`VSG_DATA_LOCK_BIT])
      |=> o_rsp.write_block && !o_rsp.nmi && !o_rsp.power_up_clear_reset)
    else $error("locked data write not dropped");
  chk_key_taken: assert property (
    (s_cfg_setup ##1 (s_cfg_access and key_ok))
      |=> (lock_reg == $past({i_pwdata[`VSG_DATA_LOCK_BIT], i_pwdata[`VSG_PROG_LOCK_BIT]})))
    else $error("keyed config write not applied");
  chk_bad_key: assert property (
    (s_cfg_setup ##1 (s_cfg_access and !key_ok)) |=> $stable(lock_reg) [*2])
    else $error("unkeyed write changed locks");
endmodule // vsg_guard

// *** bench/vsg_cpu_model.sv ***
// cpu side bus master model that issues one access per request
`timescale 1ns/1ps
module vsg_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_write,
  input wire logic i_fetch,
  input wire logic [15:0] i_addr,
  output vsg_pkg::vsg_bus_req_type o_req
);
  import vsg_pkg::*;
  // idle cycles invert the address so a stale value never looks like a fresh access
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_req <= '0;
    end else if (i_go) begin
      o_req <= '{valid: 1'b1, write: i_write, fetch: i_fetch & ~i_write, addr: i_addr};
    end else begin
      o_req <= '{valid: 1'b0, write: 1'b0, fetch: 1'b0, addr: ~o_req.addr};
    end
  end
endmodule // vsg_cpu_model

// *** bench/tb_vacant_space_and_write_guard.sv ***
// self-checking bench for the vacant space and write guard
`timescale 1ns/1ps
module tb_vacant_space_and_write_guard;
  import vsg_pkg::*;
  logic i_clk = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic go = 0, gw = 0, gf = 0, bdone = 0, pl = 1, dl = 1, ie = 0, bt = 0, plock, dlock;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] ga = '0, lastvac = '0, a;
  logic [15:0] corner [10] = '{16'h0900, 16'h07FF, 16'h0800, 16'h1000, 16'h17FF,
    16'h1800, 16'h18FF, 16'h1900, 16'hBFFF, 16'hC000};
  vsg_bus_req_type req;
  vsg_bus_rsp_type rsp, ex;
  int n_mismatch = 0, checks_done = 0, i, k;
  always #5 i_clk = ~i_clk;
  vsg_cpu_model cpu (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_write(gw), .i_fetch(gf),
    .i_addr(ga), .o_req(req));
  vsg_guard dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_req(req), .i_boot_done(bdone), .o_rsp(rsp),
    .o_program_region_write_lock(plock), .o_data_region_write_lock(dlock));
  // ****************************************
  // expectations
  // ****************************************
  function automatic logic vac(logic [15:0] x);
    return (x > 16'h07FF && x < 16'h1000) || (x >= 16'h1000 && x < 16'h1800 && bt) ||
      (x > 16'h18FF && x < 16'h2000) || (x > 16'h27FF && x < 16'hC000);
  endfunction
  function automatic vsg_bus_rsp_type want(logic w, logic f, logic [15:0] x);
    logic lk;
    lk = (x >= 16'hC000 && pl) || (x >= 16'h1800 && x <= 16'h18FF && dl);
    want.rdata_override = vac(x) && !w;
    want.rdata = vac(x) ? 16'h3FFF : 16'h0000;
    want.write_block = w && (vac(x) || lk);
    want.power_up_clear_reset = f && vac(x) && x < 16'h1000;
    want.nmi = vac(x) && ie && !(f && x < 16'h1000);
  endfunction
  task chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(1'b0, "apb hang");
      complete_run;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cfgw(input logic p, input logic d, input logic [7:0] key);
    apb(1'b1, 12'h000, {16'h0000, key, 6'h00, d, p});
    if (key == 8'hA5) begin
      pl = p;
      dl = d;
    end
    apb(1'b0, 12'h000, '0);
    chk(rd === {30'h0000_0000, dl, pl} && err === 1'b0, "lock bits read");
    chk(plock === pl && dlock === dl, "lock outputs");
  endtask
  task acc(input logic w, input logic f, input logic [15:0] x);
    @(posedge i_clk);
    go <= 1'b1;
    gw <= w;
    gf <= f;
    ga <= x;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    #1;
    ex = want(w, f & ~w, x);
    chk(rsp === ex, $sformatf("response at %h", x));
    if (vac(x)) begin
      lastvac = x;
    end
  endtask
  initial begin
    k = $urandom(32'h6228_b61e);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    chk(plock === 1'b1 && dlock === 1'b1, "locks after reset");
    apb(1'b0, 12'h004, '0);
    chk(rd === 32'h0000_0000 && err === 1'b0, "irq enable reset");
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    chk(err === 1'b1, "unmapped write");
    apb(1'b0, 12'h00C, '0);
    chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped read");
    cfgw(1'b1, 1'b1, 8'hA5);
    for (i = 0; i < 30; i++) acc(i % 3 == 2, i % 3 == 1, corner[i / 3]);
    apb(1'b1, 12'h004, 32'h0000_0001);
    ie = 1'b1;
    for (i = 0; i < 30; i++) acc(i % 3 == 2, i % 3 == 1, corner[i / 3]);
    cfgw(1'b0, 1'b1, 8'hA4);
    cfgw(1'b0, 1'b0, 8'hA5);
    acc(1'b1, 1'b0, 16'hC000);
    acc(1'b1, 1'b0, 16'h18FF);
    cfgw(1'b1, 1'b1, 8'hA5);
    @(posedge i_clk);
    bdone <= 1'b1;
    @(posedge i_clk);
    bdone <= 1'b0;
    bt = 1'b1;
    for (i = 0; i < 300; i++) begin
      if (i % 6 == 0) begin
        k = $urandom % 4;
        case (k)
          0: cfgw(1'($urandom), 1'($urandom), 8'hA5);
          1: cfgw(1'($urandom), 1'($urandom), 8'hA5 ^ 8'($urandom % 255 + 1));
          2: begin
            ie = 1'($urandom);
            apb(1'b1, 12'h004, {31'h0000_0000, ie});
          end
          default: begin
            apb(1'b0, 12'h008, '0);
            chk(rd === {15'h0000, bt, lastvac}, "status word");
          end
        endcase
      end
      a = ($urandom % 2) ? corner[$urandom % 10] ^ 16'($urandom % 4) : 16'($urandom);
      k = $urandom % 3;
      acc(k == 2, k == 1, a);
    end
    complete_run;
  end
  initial begin
    #500000;
    n_mismatch++;
    complete_run;
  end
endmodule // tb_vacant_space_and_write_guard
